// File: hw/adip_core.sv
// device side pio data-in command engine with task file on ahb-lite
// Operation
// R1: host waits for busy clear and ready set before any command.
// R2: from acceptance to completion busy or data-request is always set.
// R3: interrupt line marks most busy-to-clear transitions during a command.
// R4: only resets interrupt a command; host never writes command while busy.
// R5: pending interrupt clears on status read, reset or command write.
// R6: host loads task file parameters, then writes the command code.
// R7: per sector or block busy while preparing, then data-request and interrupt.
// R8: host reads status, reads data; device drops data-request after transfer.
// R9: sectors are 512 bytes; extended-length read appends ECC bytes.
// R10: data words are 16 bits, appended ECC bytes go 8 bits each.
// R11: multiple read moves one block per interrupt, others one sector.
// R12: a sector's status is in place before its data moves.
// R13: invalid parameter aborts: busy clear, error and abort flag, interrupt.
// R14: data error: busy clear, error bit, data-request, error code, interrupt.
// R15: failing location reported in CHS or LBA per device/head bit 6.
// R16: uncorrectable data still offered; erroneous block finished, then command ends.
// R17: errors fixed by retry deliver corrected data with no indication.
// R18: after final block read with busy and data-request clear, accept new command.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "adip_regs.svh"
module adip_core import adip_pkg::*; (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             INTRQ,
	output logic             IRQ,
	input  wire logic        MED_RDY,
	output logic             MED_START,
	output logic             MED_RESET,
	output logic [7:0]       MED_CMD,
	output logic [7:0]       MED_FEAT,
	output logic [7:0]       MED_SECCNT,
	output logic [7:0]       MED_SECNUM,
	output logic [15:0]      MED_CYL,
	output logic [7:0]       MED_DEVHEAD,
	input  wire logic        MED_PREP_DONE,
	input  wire logic        MED_ERR,
	input  wire logic [7:0]  MED_ERR_CODE,
	input  wire logic        MED_ABORT,
	input  wire logic [27:0] MED_LOC_LBA,
	input  wire logic [27:0] MED_LOC_CHS,
	input  wire logic [15:0] MED_DATA,
	input  wire logic        MED_VALID,
	output logic             MED_TAKE
);
	adip_if u_if ();

	adip_state_e state_q;
	logic [7:0]  feat_q;
	logic [7:0]  err_q;
	logic [7:0]  seccnt_q;
	logic [7:0]  secnum_q;
	logic [15:0] cyl_q;
	logic [7:0]  devhead_q;
	logic [7:0]  cmd_q;
	logic [7:0]  multi_q;
	logic        err_bit_q;
	logic        intrq_q;
	logic        lba_q;
	logic        long_q;
	logic        mult_q;
	logic [8:0]  sect_q;
	logic [8:0]  blk_q;
	logic [16:0] unit_q;
	logic        start_q;
	logic        srst_q;
	logic        tf_wr;
	logic        cmd_wr;
	logic        cmd_go;
	logic        srst;
	logic        stat_rd;
	logic        prep;
	logic        abort;
	logic        take;
	logic        last;
	logic        ecc_ph;
	logic [8:0]  multi_n;
	logic [8:0]  blk_d;
	logic [8:0]  sect_rem;
	logic [16:0] units_d;
	logic [27:0] loc;
	logic [7:0]  status;

	adip_ahb u_ahb (
		.clk       (SYS_CLK),
		.arst_n    (ARST_N),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hready    (HREADY),
		.hwdata    (HWDATA),
		.hrdata    (HRDATA),
		.hreadyout (HREADYOUT),
		.hresp     (HRESP),
		.b         (u_if.ahb)
	);

	adip_irq u_irq (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.irq    (IRQ),
		.b      (u_if.irq)
	);

	//////////////////////////////////////////////////////////////////
	// decode
	assign tf_wr   = u_if.wr && (state_q == ADIP_IDLE);
	assign cmd_wr  = u_if.wr && (u_if.addr == `ADIP_A_STATCMD);
	// command accepted only while idle and ready
	assign cmd_go  = cmd_wr && (state_q == ADIP_IDLE) && MED_RDY;
	// soft reset stops whatever runs
	assign srst    = u_if.wr && (u_if.addr == `ADIP_A_ALTCTL) && u_if.wdata[`ADIP_CTL_SRST];
	assign stat_rd = u_if.rd && (u_if.addr == `ADIP_A_STATCMD);
	assign prep    = (state_q == ADIP_BUSY) && MED_PREP_DONE && !MED_ABORT;
	assign abort   = (state_q == ADIP_BUSY) && MED_ABORT;
	assign take    = u_if.rd && (u_if.addr == `ADIP_A_DATA) && (state_q == ADIP_DRQ);
	assign last    = take && (unit_q == 17'd1);
	assign ecc_ph  = long_q && (unit_q <= `ADIP_ECC_BYTES);
	assign multi_n = (multi_q == 8'h00) ? 9'd1 : {1'b0, multi_q};
	// R11: block size for multiple read, else one sector
	assign blk_d   = !mult_q ? 9'd1 : ((multi_n < sect_q) ? multi_n : sect_q);
	// R9: long read adds the ecc bytes to one sector
	assign units_d = long_q ? (`ADIP_SECT_WORDS + `ADIP_ECC_BYTES) : {blk_d, 8'h00};
	assign sect_rem = sect_q - blk_q;
	// R15: lba or chs form chosen by mode bit latched with the command
	assign loc     = lba_q ? MED_LOC_LBA : MED_LOC_CHS;

	//////////////////////////////////////////////////////////////////
	// protocol state
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= ADIP_IDLE;
		end else if (srst) begin
			// R4: reset interrupts the command
			state_q <= ADIP_IDLE;
		end else begin
			unique case (state_q)
				ADIP_IDLE: begin
					// R2: busy set at the acceptance edge
					if (cmd_go) begin
						state_q <= ADIP_BUSY;
					end
				end
				ADIP_BUSY: begin
					// R13: abort ends with busy and data-request clear
					if (abort) begin
						state_q <= ADIP_IDLE;
					// R7: busy drops as data-request rises
					end else if (prep) begin
						state_q <= ADIP_DRQ;
					end
				end
				ADIP_DRQ: begin
					// R16 R18: end on last block or after the erroneous one
					if (last) begin
						state_q <= (err_bit_q || (sect_rem == 9'd0)) ? ADIP_IDLE : ADIP_BUSY;
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// transfer counters
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sect_q <= 9'd0;
			blk_q  <= 9'd0;
			unit_q <= 17'd0;
			lba_q  <= 1'b0;
			long_q <= 1'b0;
			mult_q <= 1'b0;
		end else if (srst) begin
			unit_q <= 17'd0;
		end else if (cmd_go) begin
			sect_q <= (seccnt_q == 8'h00) ? 9'd256 : {1'b0, seccnt_q};
			lba_q  <= devhead_q[`ADIP_DH_LBA];
			long_q <= (u_if.wdata[7:0] == `ADIP_CMD_LONG_R) || (u_if.wdata[7:0] == `ADIP_CMD_LONG_N);
			mult_q <= u_if.wdata[7:0] == `ADIP_CMD_MULT;
		end else if (prep) begin
			blk_q  <= blk_d;
			unit_q <= units_d;
		end else if (take) begin
			// R8: count down the block as the host reads it
			unit_q <= unit_q - 17'd1;
			if (last) begin
				sect_q <= sect_rem;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// task file
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			feat_q    <= 8'h00;
			seccnt_q  <= 8'h00;
			secnum_q  <= 8'h00;
			cyl_q     <= 16'h0000;
			devhead_q <= 8'h00;
			cmd_q     <= 8'h00;
			multi_q   <= `ADIP_MULTI_RST;
		end else if (prep && MED_ERR) begin
			// R15: failing sector location
			secnum_q       <= loc[7:0];
			cyl_q          <= loc[23:8];
			devhead_q[3:0] <= loc[27:24];
		end else if (tf_wr) begin
			// R6: parameters loaded ahead of the command
			unique case (u_if.addr)
				`ADIP_A_ERRFEAT: feat_q    <= u_if.wdata[7:0];
				`ADIP_A_SECCNT:  seccnt_q  <= u_if.wdata[7:0];
				`ADIP_A_SECNUM:  secnum_q  <= u_if.wdata[7:0];
				`ADIP_A_CYL:     cyl_q     <= u_if.wdata[15:0];
				`ADIP_A_DEVHEAD: devhead_q <= u_if.wdata[7:0];
				`ADIP_A_STATCMD: cmd_q     <= u_if.wdata[7:0];
				`ADIP_A_MULTI:   multi_q   <= u_if.wdata[7:0];
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// error reporting
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			err_q     <= 8'h00;
			err_bit_q <= 1'b0;
		end else if (cmd_go || srst) begin
			err_q     <= 8'h00;
			err_bit_q <= 1'b0;
		end else if (abort) begin
			// R13: error bit plus aborted flag
			err_q     <= `ADIP_ER_ABT;
			err_bit_q <= 1'b1;
		end else if (prep) begin
			// R14 R17: only errors left after retries are reported
			err_bit_q <= MED_ERR;
			err_q     <= MED_ERR ? MED_ERR_CODE : 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////
	// host interrupt line
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			intrq_q <= 1'b0;
		// R3 R7: raised when busy drops for data or abort
		end else if (prep || abort) begin
			intrq_q <= 1'b1;
		// R5: status read, command write or reset clears
		end else if (stat_rd || cmd_wr || srst) begin
			intrq_q <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			start_q <= 1'b0;
			srst_q  <= 1'b0;
		end else begin
			start_q <= cmd_go;
			srst_q  <= srst;
		end
	end

	//////////////////////////////////////////////////////////////////
	// read data and stall
	// R2 R12: status comes straight from the state, so it leads the data
	assign status = {state_q == ADIP_BUSY, MED_RDY, 2'b00, state_q == ADIP_DRQ, 2'b00, err_bit_q};

	always_comb begin
		u_if.rdata = 32'h0000_0000;
		unique case (u_if.addr)
			`ADIP_A_DATA: begin
				// R10: words, then ecc bytes in the low lane
				if (state_q == ADIP_DRQ) begin
					u_if.rdata = ecc_ph ? {24'h00_0000, MED_DATA[7:0]} : {16'h0000, MED_DATA};
				end
			end
			`ADIP_A_ERRFEAT: u_if.rdata = {24'h00_0000, err_q};
			`ADIP_A_SECCNT:  u_if.rdata = {24'h00_0000, seccnt_q};
			`ADIP_A_SECNUM:  u_if.rdata = {24'h00_0000, secnum_q};
			`ADIP_A_CYL:     u_if.rdata = {16'h0000, cyl_q};
			`ADIP_A_DEVHEAD: u_if.rdata = {24'h00_0000, devhead_q};
			`ADIP_A_STATCMD: u_if.rdata = {24'h00_0000, status};
			`ADIP_A_ALTCTL:  u_if.rdata = {24'h00_0000, status};
			`ADIP_A_ISTAT:   u_if.rdata = {28'h000_0000, u_if.istat};
			`ADIP_A_IMASK:   u_if.rdata = {28'h000_0000, u_if.imask};
			`ADIP_A_MULTI:   u_if.rdata = {24'h00_0000, multi_q};
			default:         u_if.rdata = 32'h0000_0000;
		endcase
	end

	// data reads wait for the media word
	assign u_if.stall = u_if.act_rd && (u_if.addr == `ADIP_A_DATA) && (state_q == ADIP_DRQ) && !MED_VALID;

	assign u_if.ev[`ADIP_EV_DRDY] = prep && !MED_ERR;
	assign u_if.ev[`ADIP_EV_ERR]  = prep && MED_ERR;
	assign u_if.ev[`ADIP_EV_ABT]  = abort;
	assign u_if.ev[`ADIP_EV_DONE] = last && (err_bit_q || (sect_rem == 9'd0));

	assign INTRQ       = intrq_q;
	assign MED_START   = start_q;
	assign MED_RESET   = srst_q;
	assign MED_TAKE    = take;
	assign MED_CMD     = cmd_q;
	assign MED_FEAT    = feat_q;
	assign MED_SECCNT  = seccnt_q;
	assign MED_SECNUM  = secnum_q;
	assign MED_CYL     = cyl_q;
	assign MED_DEVHEAD = devhead_q;
endmodule

// File: hw/adip_regs.svh
// register offsets, field positions and constants of the pio data-in engine
`ifndef ADIP_REGS_SVH
`define ADIP_REGS_SVH
`define ADIP_A_DATA     8'h00
`define ADIP_A_ERRFEAT  8'h04
`define ADIP_A_SECCNT   8'h08
`define ADIP_A_SECNUM   8'h0c
`define ADIP_A_CYL      8'h10
`define ADIP_A_DEVHEAD  8'h14
`define ADIP_A_STATCMD  8'h18
`define ADIP_A_ALTCTL   8'h1c
`define ADIP_A_ISTAT    8'h20
`define ADIP_A_IMASK    8'h24
`define ADIP_A_MULTI    8'h28
`define ADIP_ST_BSY     7
`define ADIP_ST_RDY     6
`define ADIP_ST_DRQ     3
`define ADIP_ST_ERR     0
`define ADIP_ER_ABT     8'h04
`define ADIP_DH_LBA     6
`define ADIP_CTL_SRST   2
`define ADIP_CMD_LONG_R 8'h22
`define ADIP_CMD_LONG_N 8'h23
`define ADIP_CMD_MULT   8'hc4
`define ADIP_SECT_WORDS 17'd256
`define ADIP_ECC_BYTES  17'd4
`define ADIP_MULTI_RST  8'h01
`define ADIP_NEV        4
`define ADIP_EV_DRDY    0
`define ADIP_EV_ERR     1
`define ADIP_EV_ABT     2
`define ADIP_EV_DONE    3
`endif

// File: hw/adip_pkg.sv
// types of the pio data-in engine
package adip_pkg;
	typedef enum logic [2:0] {
		ADIP_IDLE = 3'b001,
		ADIP_BUSY = 3'b010,
		ADIP_DRQ  = 3'b100
	} adip_state_e;
	typedef logic [7:0] adip_addr_t;
endpackage

// File: hw/adip_if.sv
// carrier between bus slave, interrupt unit and core
`timescale 1ns/1ns
interface adip_if;
	import adip_pkg::*;
	adip_addr_t  addr;
	logic        wr;
	logic        act_rd;
	logic        rd;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        stall;
	logic [3:0]  ev;
	logic [3:0]  istat;
	logic [3:0]  imask;
	modport ahb  (output addr, wr, act_rd, rd, wdata, input rdata, stall);
	modport irq  (input addr, wr, wdata, ev, output istat, imask);
	modport core (input addr, wr, act_rd, rd, wdata, istat, imask, output rdata, stall, ev);
endinterface

// File: hw/adip_ahb.sv
// ahb-lite slave front end, word accesses only
`timescale 1ns/1ns
module adip_ahb import adip_pkg::*; (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	adip_if.ahb              b
);
	logic       dp_act_q;
	logic       dp_wr_q;
	adip_addr_t dp_addr_q;

	//////////////////////////////////////////////////////////////////
	// address phase capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dp_act_q  <= 1'b0;
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hready) begin
			dp_act_q  <= hsel & htrans[1];
			dp_wr_q   <= hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////
	// data phase
	assign b.addr    = dp_addr_q;
	assign b.wr      = dp_act_q & dp_wr_q;
	assign b.act_rd  = dp_act_q & ~dp_wr_q;
	assign b.rd      = b.act_rd & ~b.stall;
	assign b.wdata   = hwdata;
	assign hrdata    = b.rdata;
	assign hreadyout = ~(b.act_rd & b.stall);
	assign hresp     = 1'b0;
endmodule

// File: hw/adip_irq.sv
// sticky event status with mask, write one to clear
`timescale 1ns/1ns
`include "adip_regs.svh"
module adip_irq import adip_pkg::*; (
	input  wire logic clk,
	input  wire logic arst_n,
	output logic      irq,
	adip_if.irq       b
);
	logic [3:0] stat_q;
	logic [3:0] mask_q;
	logic       wr_stat;

	assign wr_stat = b.wr && (b.addr == `ADIP_A_ISTAT);

	//////////////////////////////////////////////////////////////////
	// status bits, a new event wins over its clear
	genvar i;
	generate
		for (i = 0; i < `ADIP_NEV; i++) begin : g_bit
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					stat_q[i] <= 1'b0;
				end else if (b.ev[i]) begin
					stat_q[i] <= 1'b1;
				end else if (wr_stat && b.wdata[i]) begin
					stat_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= 4'h0;
		end else if (b.wr && (b.addr == `ADIP_A_IMASK)) begin
			mask_q <= b.wdata[3:0];
		end
	end

	assign b.istat = stat_q;
	assign b.imask = mask_q;
	assign irq     = |(stat_q & mask_q);
endmodule

// File: sim/adip_media.sv
// media model on the far side of the pio data-in engine
`timescale 1ns/1ns
module adip_media (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic        MED_START,
	input  wire logic        MED_RESET,
	input  wire logic        MED_TAKE,
	input  wire logic [15:0] nw,
	input  wire logic [7:0]  nb,
	input  wire logic [1:0]  mode,
	output logic             MED_PREP_DONE,
	output logic             MED_ERR,
	output logic             MED_ABORT,
	output logic [15:0]      MED_DATA,
	output logic             MED_VALID
);
	logic [15:0] seq_q;
	logic [15:0] cnt_q;
	logic [7:0]  left_q;
	logic [3:0]  dly_q;
	logic        wait_q;
	logic        strm_q;
	logic        rnd_q;
	assign MED_VALID = strm_q & rnd_q;
	// idle data lines carry the inverted word, never the valid one
	assign MED_DATA = MED_VALID ? seq_q : ~seq_q;
	always_ff @(posedge SYS_CLK) begin
		rnd_q <= ($urandom % 4) != 0;
	end
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{wait_q, strm_q, MED_PREP_DONE, MED_ERR, MED_ABORT} <= '0;
			{seq_q, cnt_q, left_q, dly_q} <= '0;
		end else begin
			{MED_PREP_DONE, MED_ERR, MED_ABORT} <= '0;
			if (MED_RESET) begin
				{wait_q, strm_q} <= '0;
			end else if (MED_START) begin
				wait_q <= 1'b1;
				left_q <= nb;
				dly_q <= 4'($urandom % 8);
				seq_q <= '0;
			end else if (wait_q && dly_q != 4'h0) begin
				dly_q <= dly_q - 4'h1;
			end else if (wait_q) begin
				wait_q <= 1'b0;
				strm_q <= mode < 2'h2;
				MED_PREP_DONE <= mode < 2'h2;
				MED_ERR <= mode == 2'h1;
				MED_ABORT <= mode == 2'h2;
				left_q <= left_q - 8'h1;
				cnt_q <= '0;
			end else if (MED_TAKE) begin
				seq_q <= seq_q + 16'h1;
				cnt_q <= cnt_q + 16'h1;
				if (cnt_q + 16'h1 == nw) begin
					strm_q <= 1'b0;
					wait_q <= left_q != 8'h0;
					dly_q <= 4'($urandom % 8);
				end
			end
		end
	end
endmodule

// File: sim/adip_core_assertions.sv
// port checks of the pio data-in engine
`timescale 1ns/1ns
module adip_core_assertions (
	input wire logic        SYS_CLK,
	input wire logic        ARST_N,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic        HREADYOUT,
	input wire logic        INTRQ,
	input wire logic        MED_START,
	input wire logic        MED_RESET,
	input wire logic        MED_PREP_DONE,
	input wire logic        MED_ABORT,
	input wire logic        MED_VALID,
	input wire logic        MED_TAKE
);
	logic busy_q;
	// first unit of a command in preparation
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			busy_q <= 1'b0;
		else
			busy_q <= MED_START | (busy_q & ~MED_PREP_DONE & ~MED_ABORT & ~MED_RESET);
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_stat_rd;
		HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == 8'h18;
	endsequence
	sequence s_int_gone;
		##[1:2] !INTRQ;
	endsequence
	a_prep_int: assert property (busy_q && MED_PREP_DONE |=> INTRQ) else $error("no interrupt on data");
	a_abort_int: assert property (busy_q && MED_ABORT |=> INTRQ) else $error("no interrupt on abort");
	a_int_cause: assert property ($rose(INTRQ) |-> $past(MED_PREP_DONE || MED_ABORT)) else $error("stray int");
	a_start_clr: assert property (MED_START |-> !INTRQ) else $error("command kept interrupt");
	a_reset_clr: assert property (MED_RESET |-> !INTRQ) else $error("reset kept interrupt");
	a_stat_clr: assert property (s_stat_rd |-> s_int_gone) else $error("status read kept interrupt");
	a_take_valid: assert property (MED_TAKE |-> MED_VALID) else $error("word taken while invalid");
	a_wait_valid: assert property (!HREADYOUT |-> !MED_VALID) else $error("wait with data valid");
	a_take_end: assert property (MED_TAKE |-> HREADYOUT) else $error("word taken in wait");
endmodule
bind adip_core adip_core_assertions chk_u (.*);

// File: sim/adip_core_tb.sv
// self-checking bench of the pio data-in engine
`timescale 1ns/1ns
`include "adip_regs.svh"
module adip_core_tb import adip_pkg::*; ;
	logic        SYS_CLK = 1'b0, ARST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, MED_RDY = 1'b1;
	logic [31:0] HADDR = '0, HWDATA = '0, HRDATA;
	logic [1:0]  HTRANS = '0, mode = '0;
	logic [2:0]  HSIZE = 3'h2;
	logic        HREADYOUT, HRESP, INTRQ, IRQ, MED_START, MED_RESET, MED_TAKE;
	logic        MED_PREP_DONE, MED_ERR, MED_ABORT, MED_VALID;
	logic [7:0]  MED_CMD, MED_FEAT, MED_SECCNT, MED_SECNUM, MED_DEVHEAD, MED_ERR_CODE = '0, nb = 8'h1;
	logic [15:0] MED_CYL, MED_DATA, nw = 16'h100, sq;
	logic [27:0] MED_LOC_LBA = '0, MED_LOC_CHS = '0, loc;
	wire         HREADY = HREADYOUT;
	int          n_errors = 0, tests_run = 0, cyc = 0;
	logic [31:0] eq[$], mq[$], gq[$];
	event        rd_ev;
	logic [7:0]  cm[4] = '{8'h20, 8'h22, 8'h23, 8'hc4};
	adip_core dut_u (.*);
	adip_media med_u (.*);
	always #4 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	always @(rd_ev) begin
		while (gq.size() != 0) begin
			tests_run++;
			if ((gq[0] & mq[0]) !== (eq[0] & mq[0])) begin
				n_errors++;
				$display("[ERR] %0t got %h want %h", $time, gq[0], eq[0]);
			end
			void'(gq.pop_front());
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end
	task automatic finish_test();
		@(negedge SYS_CLK);
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e);
		mq.push_back(m);
		gq.push_back(g);
		->rd_ev;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		logic [31:0] r;
		HSEL <= 1'b1;
		HADDR <= {24'h0, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
		@(posedge SYS_CLK);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(negedge SYS_CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
		@(posedge SYS_CLK);
		if (!w)
			chk(r, d, m);
	endtask
	// sampled at the falling edge, once the updates of the last rising edge have settled
	task automatic pin(input int s, input logic [31:0] e);
		logic [31:0] g;
		@(negedge SYS_CLK);
		case (s)
			0:       g = 32'(INTRQ);
			1:       g = 32'(IRQ);
			2:       g = 32'(INTRQ | IRQ | HRESP | !HREADYOUT);
			default: g = {8'h0, MED_CMD, MED_SECCNT, MED_DEVHEAD};
		endcase
		chk(g, e, 32'hffffffff);
		@(posedge SYS_CLK);
	endtask
	task automatic wint();
		do @(negedge SYS_CLK); while (INTRQ !== 1'b1);
		@(posedge SYS_CLK);
	endtask
	task automatic unit(input int w, input int e);
		for (int i = 0; i < w + e; i++) begin
			bus(1'b0, `ADIP_A_DATA, {16'h0, sq}, i < w ? 32'hffff : 32'hff);
			sq++;
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] n, input logic [7:0] dh, input logic [7:0] b,
			input logic [1:0] md);
		nb <= b;
		mode <= md;
		sq = '0;
		bus(1'b1, `ADIP_A_SECCNT, {24'h0, n}, '0);
		bus(1'b1, `ADIP_A_DEVHEAD, {24'h0, dh}, '0);
		bus(1'b1, `ADIP_A_STATCMD, {24'h0, c}, '0);
		pin(3, {8'h0, c, n, dh});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(38));
		repeat (6) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		pin(2, 32'h0);
		bus(1'b0, `ADIP_A_MULTI, 32'h1, 32'hff);
		bus(1'b0, 8'h30, 32'h0, 32'hffffffff);
		bus(1'b0, `ADIP_A_STATCMD, 32'h40, 32'hff);
		bus(1'b1, `ADIP_A_IMASK, 32'hf, '0);
		bus(1'b1, `ADIP_A_MULTI, 32'h2, '0);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			cmd(cm[k], k == 0 ? 8'h2 : k == 3 ? 8'h3 : 8'h1, 8'he0, k == 0 || k == 3 ? 8'h2 : 8'h1, 2'h0);
			for (int u = 0; u < (k == 0 || k == 3 ? 2 : 1); u++) begin
				nw <= (k == 3 && u == 0) ? 16'h200 : (k == 1 || k == 2) ? 16'h104 : 16'h100;
				wint();
				bus(1'b0, `ADIP_A_STATCMD, 32'h48, 32'hff);
				pin(0, 32'h0);
				bus(1'b0, `ADIP_A_DEVHEAD, 32'he0, 32'hff);
				bus(1'b0, `ADIP_A_ALTCTL, 32'h48, 32'hff);
				unit(k == 3 && u == 0 ? 512 : 256, k == 1 || k == 2 ? 4 : 0);
			end
			pin(0, 32'h0);
			bus(1'b0, `ADIP_A_STATCMD, 32'h40, 32'hff);
			bus(1'b0, `ADIP_A_ISTAT, 32'h9, 32'hf);
			pin(1, 32'h1);
			bus(1'b1, `ADIP_A_ISTAT, 32'hf, '0);
			pin(1, 32'h0);
			$display("command %h test done", cm[k]);
		end
		for (int m = 0; m < 2; m++) begin
			MED_ERR_CODE <= 8'($urandom);
			MED_LOC_LBA <= 28'($urandom);
			MED_LOC_CHS <= 28'($urandom);
			nw <= 16'h100;
			cmd(8'h20, 8'h1, m ? 8'he0 : 8'ha0, 8'h1, 2'h1);
			loc = m ? MED_LOC_LBA : MED_LOC_CHS;
			wint();
			bus(1'b0, `ADIP_A_STATCMD, 32'h49, 32'hff);
			bus(1'b0, `ADIP_A_ERRFEAT, {24'h0, MED_ERR_CODE}, 32'hff);
			bus(1'b0, `ADIP_A_SECNUM, {24'h0, loc[7:0]}, 32'hff);
			bus(1'b0, `ADIP_A_CYL, {16'h0, loc[23:8]}, 32'hffff);
			bus(1'b0, `ADIP_A_DEVHEAD, {28'h0, loc[27:24]}, 32'hf);
			unit(256, 0);
			bus(1'b0, `ADIP_A_STATCMD, 32'h40, 32'hc8);
			bus(1'b1, `ADIP_A_ISTAT, 32'hf, '0);
		end
		$display("data error test done");
		cmd(8'h20, 8'h1, 8'he0, 8'h1, 2'h2);
		wint();
		bus(1'b0, `ADIP_A_ALTCTL, 32'h41, 32'hff);
		bus(1'b0, `ADIP_A_ERRFEAT, {24'h0, `ADIP_ER_ABT}, 32'hff);
		bus(1'b0, `ADIP_A_ISTAT, 32'h4, 32'hf);
		pin(1, 32'h1);
		bus(1'b1, `ADIP_A_IMASK, 32'h0, '0);
		pin(1, 32'h0);
		bus(1'b1, `ADIP_A_ISTAT, 32'hf, '0);
		bus(1'b1, `ADIP_A_IMASK, 32'hf, '0);
		pin(0, 32'h1);
		$display("abort test done");
		cmd(8'h20, 8'h1, 8'he0, 8'h1, 2'h3);
		bus(1'b0, `ADIP_A_STATCMD, 32'hc0, 32'hff);
		bus(1'b1, `ADIP_A_ALTCTL, 32'h4, '0);
		bus(1'b1, `ADIP_A_ALTCTL, 32'h0, '0);
		bus(1'b0, `ADIP_A_STATCMD, 32'h40, 32'hff);
		// host holds back while the device is not ready
		MED_RDY <= 1'b0;
		repeat (12) @(posedge SYS_CLK);
		bus(1'b0, `ADIP_A_STATCMD, 32'h0, 32'hff);
		MED_RDY <= 1'b1;
		bus(1'b0, `ADIP_A_STATCMD, 32'h40, 32'hff);
		$display("reset and ready test done");
		finish_test();
	end
endmodule
